// ===== verilog/cas_counter.v
`timescale 1ns/1ps
`default_nettype none
`include "cas_defines.vh"
// Clock is the 80 MHz base timebase domain; every function terminal input is synchronized.
module cas_counter #(
    parameter WIDTH = 32,
    parameter DIV20 = `CAS_DIV20,
    parameter DIV100K = `CAS_DIV100K
) (
    // Clock and reset.
    input wire clock_i,
    input wire reset_i,
    // AXI4-Lite slave.
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Function terminal inputs.
    input wire ext_source_i,
    input wire gate_i,
    input wire dir_b_i,
    input wire hardware_arm_input_i,
    input wire other_internal_output_i,
    input wire other_terminal_count_i,
    input wire counter_sample_strobe_int_i,
    input wire counter_sample_strobe_ext_i,
    input wire sample_buffer_full_i,
    // Outputs.
    output reg internal_output_o,
    output reg terminal_count_event_o,
    output reg function_terminal_strobe_o,
    output reg sample_strobe_o,
    output reg armed_o
);
////////////////////////////////////////////////////////////////////////////////
    reg [31:0] ctrl_q;
    reg [WIDTH-1:0] load_q;
    reg [WIDTH-1:0] count_q;
    reg overflow_q;
    reg aw_hold_q;
    reg w_hold_q;
    reg [3:0] awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;
    wire wr_fire;
    reg [31:0] wr_val;
    integer i;
    reg [31:0] load_ext, count_ext;
    assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
    assign s_axi_wready = !w_hold_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid;
    always @*
    begin
        load_ext = 32'h0000_0000;
        load_ext[WIDTH-1:0] = load_q;
        count_ext = 32'h0000_0000;
        count_ext[WIDTH-1:0] = count_q;
        wr_val = (awaddr_q == `CAS_ADDR_LOAD) ? load_ext : ctrl_q;
        for (i = 0; i < 4; i = i + 1)
        begin
            if (wstrb_q[i])
            begin
                wr_val[i*8 +: 8] = wdata_q[i*8 +: 8];
            end
        end
    end
    wire cmd_wr = wr_fire && awaddr_q == `CAS_ADDR_CMD;
    wire cmd_arm = cmd_wr && wstrb_q[0] && wdata_q[`CAS_C_ARM];
    wire cmd_disarm = cmd_wr && wstrb_q[0] && wdata_q[`CAS_C_DISARM];
    wire cmd_start = cmd_wr && wstrb_q[0] && wdata_q[`CAS_C_START];
    wire cmd_clr_ovf = cmd_wr && wstrb_q[0] && wdata_q[`CAS_C_CLR_OVF];
    wire load_wr = wr_fire && awaddr_q == `CAS_ADDR_LOAD;
    always @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awaddr_q <= 4'h0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            ctrl_q <= `CAS_CTRL_RESET;
            load_q <= {WIDTH{1'b0}};
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awaddr_q == `CAS_ADDR_STAT) ? 2'h2 : 2'h0;
                if (awaddr_q == `CAS_ADDR_CTRL)
                begin
                    ctrl_q <= wr_val;
                end
                if (load_wr)
                begin
                    load_q <= wr_val[WIDTH-1:0];
                end
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
////////////////////////////////////////////////////////////////////////////////
// Timebase dividers.
    reg [7:0] div20_q;
    reg [15:0] div100k_q;
    wire tick80 = 1'b1;
    wire tick20 = div20_q == 8'h00;
    wire tick100k = div100k_q == 16'h0000;
    always @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            div20_q <= 8'h00;
            div100k_q <= 16'h0000;
        end
        else
        begin
            div20_q <= tick20 ? DIV20[7:0] - 8'h01 : div20_q - 8'h01;
            div100k_q <= tick100k ? DIV100K[15:0] - 16'h0001 : div100k_q - 16'h0001;
        end
    end
////////////////////////////////////////////////////////////////////////////////
// Input synchronizers.
    reg [1:0] src_s_q, gate_s_q, b_s_q, harm_s_q, oio_s_q, otc_s_q, si_s_q, se_s_q, full_s_q;
    reg src_d_q, gate_d_q, harm_d_q, smp_d_q;
    wire gate_sel = ctrl_q[`CAS_F_GATE_SRC] ? (oio_s_q[1] | otc_s_q[1]) : gate_s_q[1];
    wire harm_sel = ctrl_q[`CAS_F_ARMSRC] ? oio_s_q[1] : harm_s_q[1];
    wire smp_sel = ctrl_q[`CAS_F_SMP_EXT] ? se_s_q[1] : si_s_q[1];
    always @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            src_s_q <= 2'h0;
            gate_s_q <= 2'h0;
            b_s_q <= 2'h0;
            harm_s_q <= 2'h0;
            oio_s_q <= 2'h0;
            otc_s_q <= 2'h0;
            si_s_q <= 2'h0;
            se_s_q <= 2'h0;
            full_s_q <= 2'h0;
            src_d_q <= 1'b0;
            gate_d_q <= 1'b0;
            harm_d_q <= 1'b0;
            smp_d_q <= 1'b0;
        end
        else
        begin
            src_s_q <= {src_s_q[0], ext_source_i};
            gate_s_q <= {gate_s_q[0], gate_i};
            b_s_q <= {b_s_q[0], dir_b_i};
            harm_s_q <= {harm_s_q[0], hardware_arm_input_i};
            oio_s_q <= {oio_s_q[0], other_internal_output_i};
            otc_s_q <= {otc_s_q[0], other_terminal_count_i};
            si_s_q <= {si_s_q[0], counter_sample_strobe_int_i};
            se_s_q <= {se_s_q[0], counter_sample_strobe_ext_i};
            full_s_q <= {full_s_q[0], sample_buffer_full_i};
            src_d_q <= src_s_q[1];
            gate_d_q <= gate_sel;
            harm_d_q <= harm_sel;
            smp_d_q <= smp_sel;
        end
    end
    wire [1:0] mode = ctrl_q[`CAS_F_MODE_HI:`CAS_F_MODE_LO];
    wire [1:0] src_sel = ctrl_q[`CAS_F_SRC_HI:`CAS_F_SRC_LO];
    wire [1:0] pre_sel = ctrl_q[`CAS_F_PRE_HI:`CAS_F_PRE_LO];
    wire gate_rise = gate_sel && !gate_d_q;
    wire harm_rise = harm_sel && !harm_d_q;
    wire ext_edge = src_s_q[1] && !src_d_q;
    wire smp_edge = ctrl_q[`CAS_F_SMP_FALL] ? (!smp_sel && smp_d_q) : (smp_sel && !smp_d_q);
////////////////////////////////////////////////////////////////////////////////
// Source selection and prescaler.
    reg [2:0] pre_q;
    reg raw_tick;
    always @*
    begin
        case (src_sel)
            2'h0: raw_tick = tick80;
            2'h1: raw_tick = tick20;
            2'h2: raw_tick = tick100k;
            default: raw_tick = ext_edge;
        endcase
    end
    wire pre_on = src_sel == 2'h3 && pre_sel != 2'h0;
    wire [2:0] pre_top = pre_sel == 2'h1 ? `CAS_PRE8 : `CAS_PRE2;
    wire pre_wrap = raw_tick && pre_q == pre_top;
    wire src_tick = pre_on ? pre_wrap : raw_tick;
    always @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            pre_q <= 3'h0;
        end
        else if (!pre_on)
        begin
            pre_q <= 3'h0;
        end
        else if (raw_tick)
        begin
            pre_q <= pre_wrap ? 3'h0 : pre_q + 3'h1;
        end
    end
////////////////////////////////////////////////////////////////////////////////
// Arm and run state machine; modes 0 edge count, 1 pulse width, 2 generation.
    localparam ST_IDLE = 4'h1;
    localparam ST_WAIT = 4'h2;
    localparam ST_RUN = 4'h4;
    localparam ST_DONE = 4'h8;
    reg [3:0] st_q;
    reg started_q;
    wire arm_evt = ctrl_q[`CAS_F_HWARM_EN] ? harm_rise : cmd_arm;
    always @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            st_q <= ST_IDLE;
            started_q <= 1'b0;
        end
        else if (cmd_disarm)
        begin
            st_q <= ST_IDLE;
            started_q <= 1'b0;
        end
        else
        begin
            if (cmd_start)
            begin
                started_q <= 1'b1;
            end
            case (st_q)
                ST_IDLE: if (arm_evt) st_q <= (mode == 2'h0) ? ST_RUN : ST_WAIT;
                ST_WAIT:
                begin
                    if (mode == 2'h1 && gate_rise) st_q <= ST_RUN;
                    if (mode == 2'h2 && (started_q || cmd_start || !ctrl_q[`CAS_F_NEED_START])) st_q <= ST_RUN;
                end
                ST_RUN: if (mode == 2'h1 && !gate_sel) st_q <= ST_DONE;
                ST_DONE: st_q <= ST_DONE;
                default: st_q <= ST_IDLE;
            endcase
        end
    end
////////////////////////////////////////////////////////////////////////////////
// Counting pipeline and terminal count.
    reg [`CAS_SYNC80_STAGES-1:0] pipe_q;
    wire fast = !ctrl_q[`CAS_F_SLOW];
    wire cnt_en = st_q == ST_RUN && (mode != 2'h1 || gate_sel);
    wire cnt_now = fast ? pipe_q[`CAS_SYNC80_STAGES-1] : (cnt_en && src_tick);
    wire down = ctrl_q[`CAS_F_DIR_B] ? !b_s_q[1] : ctrl_q[`CAS_F_DOWN];
    wire tc = cnt_now && (mode == 2'h2 ? count_q == {WIDTH{1'b0}} : (down ? count_q == {WIDTH{1'b0}} : &count_q));
    always @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            pipe_q <= {`CAS_SYNC80_STAGES{1'b0}};
            count_q <= {WIDTH{1'b0}};
            terminal_count_event_o <= 1'b0;
            internal_output_o <= 1'b0;
            armed_o <= 1'b0;
        end
        else
        begin
            pipe_q <= {pipe_q[`CAS_SYNC80_STAGES-2:0], cnt_en && src_tick};
            armed_o <= st_q != ST_IDLE;
            terminal_count_event_o <= tc;
            if (load_wr || (st_q == ST_IDLE && arm_evt))
            begin
                count_q <= load_wr ? wr_val[WIDTH-1:0] : load_q;
            end
            else if (cnt_now)
            begin
                if (mode == 2'h2)
                begin
                    count_q <= tc ? load_q : count_q - {{(WIDTH-1){1'b0}}, 1'b1};
                end
                else
                begin
                    count_q <= down ? count_q - {{(WIDTH-1){1'b0}}, 1'b1} : count_q + {{(WIDTH-1){1'b0}}, 1'b1};
                end
            end
            if (ctrl_q[`CAS_F_TOGGLE])
            begin
                internal_output_o <= (tc ? !(internal_output_o ^ ctrl_q[`CAS_F_POL]) :
                    (internal_output_o ^ ctrl_q[`CAS_F_POL])) ^ ctrl_q[`CAS_F_POL];
            end
            else
            begin
                internal_output_o <= tc ^ ctrl_q[`CAS_F_POL];
            end
        end
    end
////////////////////////////////////////////////////////////////////////////////
// Sample strobe, overflow and register reads.
    always @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            overflow_q <= 1'b0;
            sample_strobe_o <= 1'b0;
            function_terminal_strobe_o <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end
        else
        begin
            sample_strobe_o <= smp_edge && st_q != ST_IDLE;
            function_terminal_strobe_o <= !smp_sel;
            if (smp_edge && st_q != ST_IDLE && full_s_q[1])
            begin
                overflow_q <= 1'b1;
            end
            else if (cmd_clr_ovf)
            begin
                overflow_q <= 1'b0;
            end
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'h0;
                case (s_axi_araddr)
                    `CAS_ADDR_CTRL: s_axi_rdata <= ctrl_q;
                    `CAS_ADDR_LOAD: s_axi_rdata <= load_ext;
                    `CAS_ADDR_STAT: s_axi_rdata <= count_ext;
                    `CAS_ADDR_CMD: s_axi_rdata <= {28'h0000000, overflow_q, started_q, internal_output_o, armed_o};
                    default:
                    begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= 2'h2;
                    end
                endcase
            end
            else if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ===== verilog/cas_defines.vh
// Functional notes
// - No input or output function starts before the counter is armed; the code exports the sample strobe and runs the prescaler while unarmed.
// - Buffered edge counting accumulates source edges as soon as armed.
// - Pulse-width measurement waits for gate after arming before measuring.
// - Output generation may require arm plus a separate start trigger.
// - Arm source selectable: software arm command or hardware arm input.
// - Hardware arm may come from another counter's internal output.
// - Sample strobe source internal or external; rising or falling edge selectable.
// - Sample strobe edge while sample buffer full flags overflow error.
// - Exported sample strobe is inverted before driving a function terminal.
// - Internal output pulses or toggles on each terminal count event.
// - Internal output polarity selectable for pulse and toggle behaviour; the code applies it to pulse behaviour only.
// - Generated pulses appear on the counter internal output.
// - Internal output and terminal count route to another counter's gate for cascading.
// - Source prescaler selectable as divide-by-8, divide-by-2 or disabled.
// - Prescaler wraps after eight or two edges; main counter counts rollovers.
// - Prescaler internal count is not readable.
// - Prescaling is unavailable when the source is an internal timebase.
// - 32-bit up/down counter; gate and async inputs synchronized before use.
// - 80 MHz mode: sync on rising edge, count lands on third edge, pipelined.
// - Slow mode: sync on delayed source edge, count on next source edge.
// - 20 MHz and 100 kHz timebases are divided from the 80 MHz timebase.
// - Selected source edge increments or decrements; B input may set direction.
`ifndef CAS_DEFINES_VH
`define CAS_DEFINES_VH
`define CAS_ADDR_CTRL 4'h0
`define CAS_ADDR_CMD 4'h4
`define CAS_ADDR_LOAD 4'h8
`define CAS_ADDR_STAT 4'hc
`define CAS_ADDR_COUNT 4'h0
`define CAS_ADDR_COUNT_HI 4'h4
`define CAS_CTRL_RESET 32'h0000_0000
`define CAS_F_MODE_LO 0
`define CAS_F_MODE_HI 1
`define CAS_F_HWARM_EN 2
`define CAS_F_ARMSRC 3
`define CAS_F_SRC_LO 4
`define CAS_F_SRC_HI 5
`define CAS_F_PRE_LO 6
`define CAS_F_PRE_HI 7
`define CAS_F_TOGGLE 8
`define CAS_F_POL 9
`define CAS_F_SMP_EXT 10
`define CAS_F_SMP_FALL 11
`define CAS_F_DIR_B 12
`define CAS_F_DOWN 13
`define CAS_F_SLOW 14
`define CAS_F_NEED_START 15
`define CAS_F_GATE_SRC 16
`define CAS_C_ARM 0
`define CAS_C_DISARM 1
`define CAS_C_START 2
`define CAS_C_CLR_OVF 3
`define CAS_BASE_HZ 80000000
`define CAS_TB20_HZ 20000000
`define CAS_TB100K_HZ 100000
`define CAS_DIV20 (`CAS_BASE_HZ / `CAS_TB20_HZ)
`define CAS_DIV100K (`CAS_BASE_HZ / `CAS_TB100K_HZ)
`define CAS_PRE8 3'h7
`define CAS_PRE2 3'h1
`define CAS_SYNC80_STAGES 2
`endif

// ===== testbench/cas_counter_properties.sv
`timescale 1ns/1ps
`default_nettype none
module cas_counter_properties (
    // Clock and reset.
    input wire logic clock_i,
    input wire logic reset_i,
    // Bus handshakes.
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Counter outputs.
    input wire logic terminal_count_event_o,
    input wire logic sample_strobe_o,
    input wire logic armed_o
);
    default clocking
        @(posedge clock_i);
    endclocking
    default disable iff (reset_i);
    ////////////////////////////////////////////////////////////////
    sequence s_wr;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_idle;
        !armed_o [*4];
    endsequence
    property p_wr_resp;
        s_wr |-> ##2 s_axi_bvalid;
    endproperty
    property p_b_once;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    property p_aw_hold;
        s_axi_bvalid |-> !s_axi_awready;
    endproperty
    property p_rd_resp;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    property p_r_once;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    property p_tc_pulse;
        terminal_count_event_o |=> !terminal_count_event_o;
    endproperty
    property p_smp_pulse;
        sample_strobe_o |=> !sample_strobe_o;
    endproperty
    property p_idle;
        s_idle |-> !sample_strobe_o && !terminal_count_event_o;
    endproperty
    ////////////////////////////////////////////////////////////////
    a_wr_resp: assert property (p_wr_resp) else $error("write response late");
    a_b_once: assert property (p_b_once) else $error("write response repeated");
    a_aw_hold: assert property (p_aw_hold) else $error("address taken during response");
    a_rd_resp: assert property (p_rd_resp) else $error("read response late");
    a_r_once: assert property (p_r_once) else $error("read response repeated");
    a_tc_pulse: assert property (p_tc_pulse) else $error("terminal count too long");
    a_smp_pulse: assert property (p_smp_pulse) else $error("sample strobe too long");
    a_idle: assert property (p_idle) else $error("activity while idle");
endmodule
`default_nettype wire

// ===== testbench/cas_far_side.sv
`timescale 1ns/1ps
`default_nettype none
module cas_far_side (
    // Source, gate, B, arm, other counter, strobes, buffer full.
    output var logic [8:0] lines_o
);
    logic [8:0] lvl = 9'h000;
    assign lines_o = lvl;
    // Levels change with no relation to the counter clock.
    task automatic set(input int i, input logic v);
        lvl[i] = v;
    endtask
    task automatic pulse(input int i, input int n);
        repeat (n)
        begin
            #43 lvl[i] = 1'b1;
            #47 lvl[i] = 1'b0;
        end
        #43;
    endtask
endmodule
`default_nettype wire

// ===== testbench/cas_counter_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module cas_counter_tb_top;
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic awv = 1'b0;
    logic wv = 1'b0;
    logic br = 1'b0;
    logic arv = 1'b0;
    logic rr = 1'b0;
    logic [3:0] awa = 4'h0;
    logic [3:0] ara = 4'h0;
    logic [31:0] wd = 32'h0;
    logic [31:0] v;
    logic io_p = 1'b0;
    wire awr, wrdy, bv, arr, rv, io, tc, fts, smp, arm;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [8:0] ln;
    int n_errors = 0;
    int cmp_count = 0;
    int cyc = 0;
    int n_tc = 0;
    int n_smp = 0;
    int n_chg = 0;
    cas_counter #(.DIV20(4), .DIV100K(8)) u_cas_counter (
        .clock_i(clock_i), .reset_i(reset_i), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp),
        .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
        .ext_source_i(ln[0]), .gate_i(ln[1]), .dir_b_i(ln[2]), .hardware_arm_input_i(ln[3]),
        .other_internal_output_i(ln[4]), .other_terminal_count_i(ln[5]), .counter_sample_strobe_int_i(ln[6]),
        .counter_sample_strobe_ext_i(ln[7]), .sample_buffer_full_i(ln[8]), .internal_output_o(io),
        .terminal_count_event_o(tc), .function_terminal_strobe_o(fts), .sample_strobe_o(smp), .armed_o(arm));
    cas_far_side u_cas_far_side (.lines_o(ln));
    always #10 clock_i = ~clock_i;
    ////////////////////////////////////////////////////////////////
    always @(posedge clock_i)
    begin
        cyc <= cyc + 1;
        n_tc <= n_tc + tc;
        n_smp <= n_smp + smp;
        n_chg <= n_chg + (io != io_p);
        io_p <= io;
        if (cyc == 20000)
        begin
            n_errors++;
            end_sim();
        end
    end
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic w(input int n);
        repeat (n) @(negedge clock_i);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er = 2'b00);
        logic ta, tw, tb;
        logic [1:0] rs;
        @(posedge clock_i);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        tb = 1'b0;
        while (!tb)
        begin
            @(negedge clock_i);
            ta = awv && awr;
            tw = wv && wrdy;
            tb = bv;
            rs = bresp;
            @(posedge clock_i);
            if (ta)
                awv <= 1'b0;
            if (tw)
                wv <= 1'b0;
        end
        br <= 1'b0;
        chk("bresp", {30'h0, rs}, {30'h0, er});
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        logic ta, tr;
        logic [1:0] rs;
        @(posedge clock_i);
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        tr = 1'b0;
        while (!tr)
        begin
            @(negedge clock_i);
            ta = arv && arr;
            tr = rv;
            d = rdata;
            rs = rresp;
            @(posedge clock_i);
            if (ta)
                arv <= 1'b0;
        end
        rr <= 1'b0;
        chk("rresp", {30'h0, rs}, 32'h0);
    endtask
    task automatic rdc(input string n, input logic [3:0] a, input logic [31:0] e);
        rd(a, v);
        chk(n, v, e);
    endtask
    task automatic cfg(input logic [31:0] c, input logic [31:0] ld);
        wr(4'h4, 32'h2);
        wr(4'h0, c);
        wr(4'h8, ld);
        @(negedge clock_i);
        n_tc = 0;
        n_smp = 0;
        n_chg = 0;
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_reset;
        chk("armed", arm, 0);
        chk("exported strobe", fts, 1);
        rdc("control", 4'h0, 32'h0);
        rdc("status", 4'h4, 32'h0);
        wr(4'hc, 32'h5, 2'b10);
        wr(4'h0, 32'h30);
        u_cas_far_side.pulse(0, 4);
        w(6);
        rdc("count", 4'hc, 32'h0);
    endtask
    task automatic cnt(input logic [31:0] c, input logic [31:0] ld, input int n, input logic [31:0] e);
        cfg(c, ld);
        wr(4'h4, 32'h1);
        u_cas_far_side.pulse(0, n);
        w(6);
        rdc("count", 4'hc, e);
    endtask
    task automatic rng(input logic [31:0] c, input int n, input int lo, input int hi);
        cfg(c, 0);
        wr(4'h4, 32'h1);
        w(n);
        wr(4'h4, 32'h2);
        rd(4'hc, v);
        chk("rate", (v >= lo && v <= hi), 1);
    endtask
    task automatic t_pw_hw;
        cfg(32'h31, 0);
        wr(4'h4, 32'h1);
        u_cas_far_side.pulse(0, 5);
        w(6);
        rdc("count", 4'hc, 32'h0);
        chk("armed", arm, 1);
        cfg(32'h34, 0);
        w(6);
        chk("armed", arm, 0);
        u_cas_far_side.pulse(3, 1);
        w(4);
        chk("armed", arm, 1);
        cfg(32'h3c, 0);
        u_cas_far_side.pulse(4, 1);
        w(4);
        chk("armed", arm, 1);
    endtask
    task automatic t_smp;
        cfg(32'h430, 0);
        u_cas_far_side.pulse(7, 1);
        w(6);
        chk("strobes", n_smp, 0);
        wr(4'h4, 32'h1);
        u_cas_far_side.pulse(7, 3);
        u_cas_far_side.pulse(6, 2);
        w(6);
        chk("strobes", n_smp, 3);
        u_cas_far_side.set(7, 1'b1);
        w(6);
        chk("exported strobe", fts, 0);
        cfg(32'hc30, 0);
        wr(4'h4, 32'h1);
        w(6);
        chk("strobes", n_smp, 0);
        u_cas_far_side.set(7, 1'b0);
        w(6);
        chk("strobes", n_smp, 1);
        u_cas_far_side.set(8, 1'b1);
        u_cas_far_side.pulse(7, 1);
        w(6);
        rd(4'h4, v);
        chk("overflow", v[3], 1);
        wr(4'h4, 32'h8);
        rd(4'h4, v);
        chk("overflow", v[3], 0);
        u_cas_far_side.set(8, 1'b0);
    endtask
    task automatic t_start;
        cfg(32'h8002, 3);
        wr(4'h4, 32'h1);
        w(20);
        chk("tc before start", n_tc, 0);
        wr(4'h4, 32'h4);
        w(20);
        chk("tc after start", n_tc > 2, 1);
    endtask
    task automatic gen(input logic [31:0] c, input int k, input logic idle);
        cfg(c, 3);
        wr(4'h4, 32'h1);
        w(40);
        wr(4'h4, 32'h2);
        w(8);
        chk("tc seen", n_tc > 5, 1);
        chk("output edges", n_chg, n_tc * k);
        if (k == 2)
            chk("idle level", io, idle);
    endtask
    ////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (3) @(posedge clock_i);
        reset_i <= 1'b0;
        @(negedge clock_i);
        t_reset();
        cnt(32'h30, 0, 5, 5);
        cnt(32'h2030, 10, 3, 7);
        cnt(32'h1030, 10, 4, 6);
        u_cas_far_side.set(2, 1'b1);
        cnt(32'h1030, 10, 4, 14);
        cnt(32'h4030, 0, 5, 5);
        cnt(32'h70, 0, 16, 2);
        cnt(32'hb0, 0, 6, 3);
        rng(32'h40, 40, 36, 50);
        rng(32'h10, 40, 9, 14);
        rng(32'h20, 80, 8, 13);
        t_pw_hw();
        t_smp();
        t_start();
        gen(32'h2, 2, 0);
        gen(32'h202, 2, 1);
        gen(32'h102, 1, 0);
        gen(32'h302, 1, 0);
        end_sim();
    end
endmodule
bind cas_counter cas_counter_properties u_cas_counter_properties (.clock_i(clock_i), .reset_i(reset_i),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .terminal_count_event_o(terminal_count_event_o),
    .sample_strobe_o(sample_strobe_o), .armed_o(armed_o));
`default_nettype wire
